// ---- verilog/blinker_pkg.sv ----
/*
  shared constants for the two-wire led blinker: register indices, reset values,
  led selector codes, timing counts and the controller's own register map.
  assumes a 40 MHz hclk on both ends.
*/
`default_nettype none

package blinker_pkg;

  localparam int CLK_NS = 25;
  localparam int CLK_HZ = 40_000_000;

  // slave address bits 6:3; bits 2:0 come from the address select inputs
  localparam logic [3:0] SLAVE_ADDR_HI = 4'hC;

  // spike suppression, longest time rounds down
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS / CLK_NS < 1) ? 1 : SPIKE_NS / CLK_NS;

  // blink base tick: period = (prescaler + 1) / 38 s split in 256 duty steps
  localparam int BLINK_DIV = 38;
  localparam int BLINK_STEPS = 256;
  localparam int TICK_CYC = CLK_HZ / (BLINK_DIV * BLINK_STEPS);

  // register indices of the command byte's low four bits
  localparam logic [3:0] REG_IN0 = 4'h0;
  localparam logic [3:0] REG_IN1 = 4'h1;
  localparam logic [3:0] REG_PRESCALE0 = 4'h2;
  localparam logic [3:0] REG_DUTY0 = 4'h3;
  localparam logic [3:0] REG_PRESCALE1 = 4'h4;
  localparam logic [3:0] REG_DUTY1 = 4'h5;
  localparam logic [3:0] REG_SELECT0 = 4'h6;
  localparam logic [3:0] REG_SELECT3 = 4'h9;
  localparam int AUTO_INC_BIT = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PSC_RST = 8'hFF;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [31:0] LS_RST = 32'h55555555;

  typedef enum logic [1:0] {
    LED_ON = 2'b00,
    LED_OFF = 2'b01,
    LED_GEN0 = 2'b10,
    LED_GEN1 = 2'b11
  } led_sel_e;

  // controller side
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam logic [31:0] HOST_CMD_OFS = 32'h00000000;
  localparam logic [31:0] HOST_STAT_OFS = 32'h00000004;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_NACK_BIT = 3;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;

endpackage

`default_nettype wire

// ---- verilog/twowire_if.sv ----
/*
  two-wire bus between the controller and the blinker.
  both lines are open drain with pull-ups: a line is low when any enabled driver drives low.
*/
`timescale 1ns/100ps
`default_nettype none

interface twowire_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // pull-up resolution without any high-impedance value
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
    output host_sda_o, output host_sda_oe_n);
endinterface

`default_nettype wire

// ---- verilog/line_filter.sv ----
/*
  three-stage synchroniser plus glitch filter for one bus line.
  assumes din is asynchronous to clk; dout follows only after a level held
  longer than STABLE_CYC cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module line_filter #(
  parameter int STABLE_CYC = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic s1_q, s2_q, s3_q;
  logic [3:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a pulse of STABLE_CYC cycles or less never reaches dout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      dout <= 1'b1;
    end else if (s2_q != s3_q || s3_q == dout) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == 4'(STABLE_CYC)) begin
      dout <= s3_q;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // line_filter

`default_nettype wire

// ---- verilog/blinker_dev.sv ----
/*
  two-wire slave led blinker: register file, serial slave and two blink generators
  driving sixteen open-drain led outputs.
  assumes hclk at 40 MHz stands in for the internal oscillator and hresetn is power-on reset.
*/
// Implementation choices: the AHB-Lite register port and the register addresses.
// Functional notes
// - power-on reset loads defaults, leds off
// - low reset pin holds registers and fsm
// - controller holds reset pin low long enough
// - controller avoids reset during a transfer
// - transfers start only on idle bus
// - one bit per clock, sda stable high
// - sda edges with scl high: start/stop
// - eight data bits then one acknowledge
// - master clocks ninth pulse, transmitter releases
// - slave receiver pulls sda low to acknowledge
// - master acknowledges all but last read
// - nack ends read, slave releases sda
// - filter spikes up to 50 ns
// - address C0h with selects low
// - command 12h writes prescalers, duties, selectors
// - period equals (prescaler + 1) / 38
// - on fraction equals (256 - duty) / 256
// - plain read uses stored command pointer
// - selector: on, off, first or second generator
// - auto-increment advances pointer, wraps after last
`timescale 1ns/100ps
`default_nettype none

module blinker_dev #(
  parameter int TICK_CYC = blinker_pkg::TICK_CYC,
  parameter int SPIKE_CYC = blinker_pkg::SPIKE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  twowire_if.dev bus,
  input wire logic [2:0] addr_sel,
  input wire logic ext_rst_n,
  input wire logic [15:0] led_i,
  output logic [15:0] led_o,
  output logic [15:0] led_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_CMD, ST_WR, ST_RD, ST_MACK
  } slave_st_e;

  localparam int TW = $clog2(TICK_CYC);

  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    next_ptr = (p >= blinker_pkg::REG_SELECT3) ? 4'h0 : p + 4'h1;
  endfunction

  logic [19:0] s1_q, s2_q, s3_q, pin_q;
  logic srst;
  logic scl_f, sda_f, scl_p, sda_p;
  logic start_ev, stop_ev, scl_rise, scl_fall;
  slave_st_e st_q, kind_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, rd_byte, ctrl_q;
  logic nack_q, wr_stb_q, cmd_stb_q, adv_stb_q, sda_low;
  logic [7:0] psc_q [2];
  logic [7:0] duty_q [2];
  logic [31:0] ls_q;
  logic [TW-1:0] tick_q;
  logic [7:0] pcnt_q [2];
  logic [7:0] phase_q [2];
  logic [1:0] blink_on;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: reset pin, address selects, led pins

  // a bit changes once the second and third stage agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 20'h80000;
      s2_q <= 20'h80000;
      s3_q <= 20'h80000;
      pin_q <= 20'h80000;
    end else begin
      s1_q <= {ext_rst_n, addr_sel, led_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
    end
  end

  assign srst = ~pin_q[19];

  line_filter #(.STABLE_CYC(SPIKE_CYC)) scl_filt (
    .clk(hclk), .rst_n(hresetn), .din(bus.scl), .dout(scl_f));
  line_filter #(.STABLE_CYC(SPIKE_CYC)) sda_filt (
    .clk(hclk), .rst_n(hresetn), .din(bus.sda), .dout(sda_f));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // sda moving while scl is high is never data
  assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      kind_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      nack_q <= 1'b0;
      wr_stb_q <= 1'b0;
      cmd_stb_q <= 1'b0;
      adv_stb_q <= 1'b0;
    end else if (srst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      wr_stb_q <= 1'b0;
      cmd_stb_q <= 1'b0;
      adv_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      cmd_stb_q <= 1'b0;
      adv_stb_q <= 1'b0;
      if (start_ev) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
      end else if (stop_ev) begin
        st_q <= ST_IDLE;
      end else if (scl_rise) begin
        case (st_q)
          ST_ADDR, ST_CMD, ST_WR: begin
            shift_q <= {shift_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
          end
          ST_RD: cnt_q <= cnt_q + 4'h1;
          ST_MACK: nack_q <= sda_f;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_q)
          ST_ADDR, ST_CMD, ST_WR: begin
            if (cnt_q == 4'h8) begin
              if (st_q == ST_ADDR && shift_q[7:1] != {blinker_pkg::SLAVE_ADDR_HI, pin_q[18:16]})
                st_q <= ST_IDLE;
              else begin
                kind_q <= st_q;
                st_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            cnt_q <= 4'h0;
            case (kind_q)
              ST_ADDR: begin
                if (shift_q[0]) begin
                  st_q <= ST_RD;
                  shift_q <= rd_byte;
                  adv_stb_q <= 1'b1;
                end else begin
                  st_q <= ST_CMD;
                end
              end
              ST_CMD: begin
                cmd_stb_q <= 1'b1;
                st_q <= ST_WR;
              end
              default: begin
                // byte is only committed once its acknowledge has completed
                wr_stb_q <= 1'b1;
                adv_stb_q <= 1'b1;
                st_q <= ST_WR;
              end
            endcase
          end
          ST_RD: begin
            if (cnt_q == 4'h8)
              st_q <= ST_MACK;
            else
              shift_q <= {shift_q[6:0], 1'b0};
          end
          ST_MACK: begin
            if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              st_q <= ST_RD;
              cnt_q <= 4'h0;
              shift_q <= rd_byte;
              adv_stb_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sda only changes after scl has been seen low
  assign sda_low = (st_q == ST_ACK) || (st_q == ST_RD && !shift_q[7]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bus.dev_sda_oe_n <= 1'b1;
    else if (srst) bus.dev_sda_oe_n <= 1'b1;
    else bus.dev_sda_oe_n <= ~sda_low;
  end

  assign bus.dev_sda_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_q <= blinker_pkg::CTRL_RST;
    else if (srst) ctrl_q <= blinker_pkg::CTRL_RST;
    else if (cmd_stb_q) ctrl_q <= shift_q;
    else if (adv_stb_q && ctrl_q[blinker_pkg::AUTO_INC_BIT])
      ctrl_q[3:0] <= next_ptr(ctrl_q[3:0]);
  end

  // input registers take writes with an acknowledge but no effect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_q[0] <= blinker_pkg::PSC_RST;
      psc_q[1] <= blinker_pkg::PSC_RST;
      duty_q[0] <= blinker_pkg::DUTY_RST;
      duty_q[1] <= blinker_pkg::DUTY_RST;
      ls_q <= blinker_pkg::LS_RST;
    end else if (srst) begin
      psc_q[0] <= blinker_pkg::PSC_RST;
      psc_q[1] <= blinker_pkg::PSC_RST;
      duty_q[0] <= blinker_pkg::DUTY_RST;
      duty_q[1] <= blinker_pkg::DUTY_RST;
      ls_q <= blinker_pkg::LS_RST;
    end else if (wr_stb_q) begin
      case (ctrl_q[3:0])
        blinker_pkg::REG_PRESCALE0: psc_q[0] <= shift_q;
        blinker_pkg::REG_DUTY0: duty_q[0] <= shift_q;
        blinker_pkg::REG_PRESCALE1: psc_q[1] <= shift_q;
        blinker_pkg::REG_DUTY1: duty_q[1] <= shift_q;
        4'h6: ls_q[7:0] <= shift_q;
        4'h7: ls_q[15:8] <= shift_q;
        4'h8: ls_q[23:16] <= shift_q;
        4'h9: ls_q[31:24] <= shift_q;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ctrl_q[3:0])
      blinker_pkg::REG_IN0: rd_byte = pin_q[7:0];
      blinker_pkg::REG_IN1: rd_byte = pin_q[15:8];
      blinker_pkg::REG_PRESCALE0: rd_byte = psc_q[0];
      blinker_pkg::REG_DUTY0: rd_byte = duty_q[0];
      blinker_pkg::REG_PRESCALE1: rd_byte = psc_q[1];
      blinker_pkg::REG_DUTY1: rd_byte = duty_q[1];
      4'h6: rd_byte = ls_q[7:0];
      4'h7: rd_byte = ls_q[15:8];
      4'h8: rd_byte = ls_q[23:16];
      4'h9: rd_byte = ls_q[31:24];
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink generators

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_q <= '0;
    else if (tick_q == TW'(TICK_CYC - 1)) tick_q <= '0;
    else tick_q <= tick_q + 1'b1;
  end

  // each generator steps its phase once per (prescaler + 1) base ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcnt_q[0] <= 8'h00;
      pcnt_q[1] <= 8'h00;
      phase_q[0] <= 8'h00;
      phase_q[1] <= 8'h00;
    end else if (srst) begin
      pcnt_q[0] <= 8'h00;
      pcnt_q[1] <= 8'h00;
      phase_q[0] <= 8'h00;
      phase_q[1] <= 8'h00;
    end else if (tick_q == TW'(TICK_CYC - 1)) begin
      for (int g = 0; g < 2; g++) begin
        if (pcnt_q[g] >= psc_q[g]) begin
          pcnt_q[g] <= 8'h00;
          phase_q[g] <= phase_q[g] + 8'h01;
        end else begin
          pcnt_q[g] <= pcnt_q[g] + 8'h01;
        end
      end
    end
  end

  assign blink_on[0] = phase_q[0] >= duty_q[0];
  assign blink_on[1] = phase_q[1] >= duty_q[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_oe_n <= 16'hFFFF;
    end else begin
      for (int i = 0; i < 16; i++) begin
        case (blinker_pkg::led_sel_e'(ls_q[2*i +: 2]))
          blinker_pkg::LED_ON: led_oe_n[i] <= 1'b0;
          blinker_pkg::LED_GEN0: led_oe_n[i] <= ~blink_on[0];
          blinker_pkg::LED_GEN1: led_oe_n[i] <= ~blink_on[1];
          default: led_oe_n[i] <= 1'b1;
        endcase
      end
    end
  end

  assign led_o = 16'h0000;
endmodule // blinker_dev

`default_nettype wire

// ---- verilog/twowire_master.sv ----
/*
  two-wire bus controller with an ahb-lite register port.
  assumes one slave on the bus that never stretches scl; scl is made here by a divider.
*/
`timescale 1ns/100ps
`default_nettype none

module twowire_master #(
  parameter int QTR_CYC = blinker_pkg::QTR_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  twowire_if.host bus
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} mst_st_e;

  mst_st_e st_q;
  logic wr_pend_q;
  logic [31:0] addr_q;
  logic [6:0] qcnt_q;
  logic tick;
  logic [1:0] step_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q, rx_q;
  logic rd_q, nack_q, stop_q, ack_q, scl_q, sda_q, sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 32'h00000000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_q <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_q <= hwrite;
        addr_q <= haddr;
        if (haddr == blinker_pkg::HOST_STAT_OFS)
          hrdata <= {16'h0000, rx_q, 6'h00, ack_q, st_q != M_IDLE};
        else
          hrdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit engine: four quarter-period steps per bit

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) qcnt_q <= 7'h00;
    else if (st_q == M_IDLE || qcnt_q == 7'(QTR_CYC - 1)) qcnt_q <= 7'h00;
    else qcnt_q <= qcnt_q + 7'h01;
  end

  assign tick = qcnt_q == 7'(QTR_CYC - 1);

  line_filter #(.STABLE_CYC(blinker_pkg::SPIKE_CYC)) sda_filt (
    .clk(hclk), .rst_n(hresetn), .din(bus.sda), .dout(sda_f));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= M_IDLE;
      step_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      stop_q <= 1'b0;
      ack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (st_q == M_IDLE) begin
      // a command written while busy is dropped
      if (wr_pend_q && addr_q == blinker_pkg::HOST_CMD_OFS) begin
        tx_q <= hwdata[blinker_pkg::CMD_DATA_LSB +: 8];
        rd_q <= hwdata[blinker_pkg::CMD_READ_BIT];
        nack_q <= hwdata[blinker_pkg::CMD_NACK_BIT];
        stop_q <= hwdata[blinker_pkg::CMD_STOP_BIT];
        step_q <= 2'h0;
        bit_q <= 4'h0;
        st_q <= hwdata[blinker_pkg::CMD_START_BIT] ? M_START : M_BITS;
      end
    end else if (tick) begin
      step_q <= step_q + 2'h1;
      case (st_q)
        M_START: begin
          case (step_q)
            2'h0: sda_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b0;
            default: begin
              scl_q <= 1'b0;
              st_q <= M_BITS;
            end
          endcase
        end
        M_BITS: begin
          case (step_q)
            2'h0: begin
              if (bit_q == 4'h8) sda_q <= rd_q ? nack_q : 1'b1;
              else sda_q <= rd_q ? 1'b1 : tx_q[7];
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bit_q == 4'h8) ack_q <= ~sda_f;
              else rx_q <= {rx_q[6:0], sda_f};
            end
            default: begin
              scl_q <= 1'b0;
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) st_q <= stop_q ? M_STOP : M_IDLE;
            end
          endcase
        end
        default: begin
          case (step_q)
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            default: st_q <= M_IDLE;
          endcase
        end
      endcase
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = scl_q;
  assign bus.host_sda_oe_n = sda_q;
endmodule // twowire_master

`default_nettype wire

// ---- test/blinker_properties.sv ----
/*
  checker for the two-wire link: slave sda timing against scl.
  assumes it sits beside the twowire_if, all in the hclk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module blinker_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic scl_q, sda_q, first_q, rd_q, acked_q;
  logic [3:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // raw pin levels; the slave filters, so its view lags by a few cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      rd_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (scl && scl_q && sda_q && !sda) begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
    end else if (scl && !scl_q) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h8) first_q <= 1'b0;
      if (first_q && cnt_q == 4'h7) rd_q <= sda;
      if (first_q && cnt_q == 4'h8) acked_q <= !dev_sda_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  reset_release_a: assert property ($rose(hresetn) |-> scl && sda && dev_sda_oe_n)
    else $error("lines busy after reset");
  sda_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("slave moved sda with scl high");
  ack_stable_a: assert property ($rose(scl) && !dev_sda_oe_n |-> !dev_sda_oe_n [*8])
    else $error("slave low not held");
  ninth_only_a: assert property ($rose(scl) && !dev_sda_oe_n && (first_q || !rd_q)
    |-> cnt_q == 4'h8) else $error("slave pulled sda off the ninth bit");
  ack_due_a: assert property ($fell(scl) && cnt_q == 4'h8 && !first_q && !rd_q && acked_q
    |-> ##[1:10] !dev_sda_oe_n) else $error("data byte not acknowledged");
  ack_release_a: assert property ($fell(scl) && cnt_q == 4'h0 && !first_q && !rd_q
    |-> ##[1:10] dev_sda_oe_n) else $error("sda held after acknowledge");
  read_release_a: assert property ($rose(scl) && cnt_q == 4'h8 && rd_q && !first_q
    |-> dev_sda_oe_n) else $error("slave drove master acknowledge slot");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high too short");
  stop_idle_a: assert property (scl && $rose(sda) |=> (scl && sda) [*8])
    else $error("bus not idle after stop");
endmodule // blinker_properties

`default_nettype wire

// ---- test/led_blinker_i2c_slave_reset_tb.sv ----
/*
  self-checking bench: controller and blinker joined over the two-wire link.
  assumes the design files and blinker_properties are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module led_blinker_i2c_slave_reset_tb;
  localparam int TICK = 4;
  // generator 1 gets prescaler 09h and duty C0h
  localparam int PER1 = 10 * 256 * TICK;
  localparam int ON1 = (256 - 192) * 10 * TICK;
  localparam logic [7:0] DEF [11] = '{8'hC0, 8'h12, 8'hFF, 8'h80, 8'hFF, 8'h80, 8'h55, 8'h55,
    8'h55, 8'h55, 8'hFF};
  localparam logic [7:0] PRG [11] = '{8'hC0, 8'h12, 8'h25, 8'h80, 8'h09, 8'hC0, 8'h00, 8'hFA,
    8'h55, 8'h55, 8'h00};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_rst_n;
  logic [15:0] led_o;
  logic [1:0] htrans;
  logic [2:0] hsize, addr_sel;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] led_oe_n;
  int n_errors, total_checks;

  twowire_if i_twowire_if ();
  twowire_master i_twowire_master (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(i_twowire_if));
  // led pins are open drain with pull-ups, so the pin level is the enable itself
  blinker_dev #(.TICK_CYC(TICK)) i_blinker_dev (.hclk(hclk), .hresetn(hresetn),
    .bus(i_twowire_if), .addr_sel(addr_sel), .ext_rst_n(ext_rst_n), .led_i(led_oe_n),
    .led_o(led_o), .led_oe_n(led_oe_n));
  blinker_properties i_blinker_properties (.hclk(hclk), .hresetn(hresetn),
    .scl(i_twowire_if.scl),
    .sda(i_twowire_if.sda), .dev_sda_oe_n(i_twowire_if.dev_sda_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // flags: 01 start, 02 stop, 04 read, 08 nack; waits until the byte is done
  task automatic op(input logic [7:0] fl, input logic [7:0] b, output logic [31:0] st);
    ahb(1'b1, blinker_pkg::HOST_CMD_OFS, {16'h0000, b, fl}, st);
    do ahb(1'b0, blinker_pkg::HOST_STAT_OFS, 32'h00000000, st);
    while (st[blinker_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic readback(input logic [7:0] e [11], input int n);
    logic [31:0] st;
    op(8'h01, 8'hC0, st);
    op(8'h00, 8'h12, st);
    op(8'h01, 8'hC1, st);
    for (int i = 0; i < n; i++) begin
      op((i == n - 1) ? 8'h0E : 8'h04, 8'h00, st);
      chk({8'h00, st[15:8]}, {8'h00, e[i + 2]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_address();
    logic [31:0] st;
    ahb(1'b0, 32'h00000008, 32'h00000000, st);
    chk(st[15:0], 16'h0000);
    chk({15'h0000, hresp}, 16'h0000);
    chk(led_o, 16'h0000);
    op(8'h03, 8'hC2, st);
    chk({15'h0000, st[1]}, 16'h0000);
    addr_sel <= 3'h5;
    repeat (4) @(posedge hclk);
    op(8'h03, 8'hCA, st);
    chk({15'h0000, st[1]}, 16'h0001);
    op(8'h03, 8'hC0, st);
    chk({15'h0000, st[1]}, 16'h0000);
    addr_sel <= 3'h0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic t_program();
    logic [31:0] st;
    for (int i = 0; i < 10; i++) begin
      op((i == 0) ? 8'h01 : (i == 9) ? 8'h02 : 8'h00, PRG[i], st);
      chk({15'h0000, st[1]}, 16'h0001);
    end
    readback(PRG, 8);
    op(8'h01, 8'hC1, st);
    op(8'h0E, 8'h00, st);
    chk({12'h000, st[11:8]}, 16'h0000);
    chk(led_oe_n | 16'h00F0, 16'hFFF0);
  endtask

  // one full period: the on count is exact whatever the starting phase
  task automatic t_blink();
    int on;
    on = 0;
    repeat (PER1) begin
      @(posedge hclk);
      if (led_oe_n[6] === 1'b0) on++;
    end
    chk(16'(on), 16'(ON1));
  endtask

  // only while the bus is idle: a reset mid-byte could fake a stop
  task automatic t_ext_reset();
    ext_rst_n <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(led_oe_n, 16'hFFFF);
    ext_rst_n <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(led_oe_n, 16'hFFFF);
    readback(DEF, 9);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    #2_500_000;
    n_errors++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    addr_sel = 3'h0;
    ext_rst_n = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(led_oe_n, 16'hFFFF);
    readback(DEF, 9);
    t_address();
    t_program();
    t_blink();
    t_ext_reset();
    finish_test();
  end
endmodule // led_blinker_i2c_slave_reset_tb

`default_nettype wire
